/* File: ldcb_map.svh */
// Index map, field positions and reset values of the logical device bank
`ifndef LDCB_MAP_SVH
`define LDCB_MAP_SVH
`define LDCB_IDX_DEVSEL 8'h07
`define LDCB_IDX_POWER 8'h22
`define LDCB_IDX_ACTIVATE 8'h30
`define LDCB_IDX_LD_FIRST 8'h30
`define LDCB_IDX_RSVD_FIRST 8'h31
`define LDCB_IDX_RSVD_LAST 8'h5F
`define LDCB_IDX_BASE_PRI_HI 8'h60
`define LDCB_IDX_BASE_PRI_LO 8'h61
`define LDCB_IDX_BASE_SEC_HI 8'h62
`define LDCB_IDX_BASE_SEC_LO 8'h63
`define LDCB_IDX_IRQ 8'h70
`define LDCB_IDX_IRQ_GAP 8'h71
`define LDCB_IDX_IRQ2 8'h72
`define LDCB_IDX_IRQ2_GAP 8'h73
`define LDCB_IDX_DMA 8'h74
`define LDCB_IDX_DMA2 8'h75
`define LDCB_IDX_UNIMPL_FIRST 8'h76
`define LDCB_IDX_UNIMPL_LAST 8'hDF
`define LDCB_ACT_BIT 0
`define LDCB_RST_ZERO 8'h00
`define LDCB_RST_DMA 8'h04
`define LDCB_DEV_FDC 0
`define LDCB_DEV_PP 3
`define LDCB_DEV_SP1 4
`define LDCB_DEV_SP2 5
`define LDCB_DEV_KBD 7
`define LDCB_PWR_FDC 4'h8
`define LDCB_PWR_PP 4'hB
`define LDCB_PWR_SP1 4'hC
`define LDCB_PWR_SP2 4'hD
`define LDCB_PWR_NONE 4'h0
`define LDCB_BASE_MIN 12'h100
`define LDCB_BASE_MAX8 12'hFF8
`define LDCB_BASE_MAX4 12'hFFC
`define LDCB_IRQ_EDGE_HIGH 1'b1
`endif

/* File: ldcb_pkg.sv */
// Types shared by the logical device bank
package ldcb_pkg;
  typedef struct packed {
    logic idxWrite;
    logic dataWrite;
    logic dataRead;
    logic [7:0] wdata;
  } ldcb_host_t;
  typedef struct packed {
    logic active;
    logic [15:0] basePri;
    logic [15:0] baseSec;
    logic [7:0] irqSel;
    logic [7:0] irqSel2;
    logic [7:0] dmaSel;
  } ldcb_bank_t;
  typedef enum logic [1:0] {ACC_NONE, ACC_INDEX, ACC_WRITE, ACC_READ} ldcb_acc_t;
endpackage

/* File: ldcb_bank.sv */
// One logical device register bank
`timescale 1ns/1ns
`include "ldcb_map.svh"
module ldcb_bank #(
  parameter bit HAS_BASE = 1'b1,
  parameter bit HAS_SEC = 1'b0,
  parameter bit HAS_IRQ2 = 1'b0,
  parameter bit HAS_DMA = 1'b0
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hostResetDrv,
  input wire logic wrEn,
  input wire logic [7:0] idx,
  input wire logic [7:0] wrData,
  input wire logic pwrWr,
  input wire logic pwrData,
  output ldcb_pkg::ldcb_bank_t regs,
  output logic [7:0] rdData
);
  localparam ldcb_pkg::ldcb_bank_t RST_VAL = '{
    active: 1'b0, basePri: {`LDCB_RST_ZERO, `LDCB_RST_ZERO},
    baseSec: {`LDCB_RST_ZERO, `LDCB_RST_ZERO}, irqSel: `LDCB_RST_ZERO,
    irqSel2: `LDCB_RST_ZERO, dmaSel: HAS_DMA ? `LDCB_RST_DMA : `LDCB_RST_ZERO};
  ldcb_pkg::ldcb_bank_t regs_r;
  ldcb_pkg::ldcb_bank_t regs_nxt;
  // ----------------------------------------
  // Register update
  // ----------------------------------------
  always_comb begin
    regs_nxt = regs_r;
    if (pwrWr) begin
      regs_nxt.active = pwrData;
    end
    if (wrEn) begin
      case (idx)
        `LDCB_IDX_ACTIVATE: regs_nxt.active = wrData[`LDCB_ACT_BIT];
        `LDCB_IDX_BASE_PRI_HI: if (HAS_BASE) regs_nxt.basePri[15:8] = wrData;
        `LDCB_IDX_BASE_PRI_LO: if (HAS_BASE) regs_nxt.basePri[7:0] = wrData;
        `LDCB_IDX_BASE_SEC_HI: if (HAS_SEC) regs_nxt.baseSec[15:8] = wrData;
        `LDCB_IDX_BASE_SEC_LO: if (HAS_SEC) regs_nxt.baseSec[7:0] = wrData;
        `LDCB_IDX_IRQ: regs_nxt.irqSel = wrData;
        `LDCB_IDX_IRQ2: if (HAS_IRQ2) regs_nxt.irqSel2 = wrData;
        `LDCB_IDX_DMA: if (HAS_DMA) regs_nxt.dmaSel = wrData;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regs_r <= RST_VAL;
    end else if (hostResetDrv) begin
      regs_r <= RST_VAL;
    end else begin
      regs_r <= regs_nxt;
    end
  end
  assign regs = regs_r;
  // ----------------------------------------
  // Read view, absent fields read zero
  // ----------------------------------------
  always_comb begin
    case (idx)
      `LDCB_IDX_ACTIVATE: rdData = {7'h00, regs_r.active};
      `LDCB_IDX_BASE_PRI_HI: rdData = HAS_BASE ? regs_r.basePri[15:8] : `LDCB_RST_ZERO;
      `LDCB_IDX_BASE_PRI_LO: rdData = HAS_BASE ? regs_r.basePri[7:0] : `LDCB_RST_ZERO;
      `LDCB_IDX_BASE_SEC_HI: rdData = HAS_SEC ? regs_r.baseSec[15:8] : `LDCB_RST_ZERO;
      `LDCB_IDX_BASE_SEC_LO: rdData = HAS_SEC ? regs_r.baseSec[7:0] : `LDCB_RST_ZERO;
      `LDCB_IDX_IRQ: rdData = regs_r.irqSel;
      `LDCB_IDX_IRQ2: rdData = HAS_IRQ2 ? regs_r.irqSel2 : `LDCB_RST_ZERO;
      `LDCB_IDX_DMA: rdData = HAS_DMA ? regs_r.dmaSel : `LDCB_RST_ZERO;
      default: rdData = `LDCB_RST_ZERO;
    endcase
  end
endmodule // ldcb_bank

/* File: ldcb_config_bank.sv */
// Logical device configuration bank behind the index and data ports
//
// Function
// - One bank per logical device; register 0x07 picks the bank at 0x30-0xFF.
// - Index port picks a register; data port reads or writes it.
// - Logical device registers reachable only in configuration state.
// - Activation bit 0 makes the selected device active; default zero.
// - Indices 0x31 to 0x5F ignore writes and read zero.
// - Primary base address at 0x60 high and 0x61 low; default zero.
// - Second base address at 0x62 high and 0x63 low where used.
// - Unused base address registers ignore writes and read zero.
// - Every bank has interrupt level select at 0x70, default zero.
// - Only keyboard bank has second interrupt select at 0x72.
// - Interrupts default to edge triggered, active high.
// - Indices 0x71 and 0x73 ignore writes and read zero.
// - DMA select 0x74 only for floppy, serial 2, parallel; default 0x04.
// - Index 0x75 ignores writes and reads zero in every bank.
// - Indices 0x76 to 0xDF ignore writes and read zero.
// - Device on when activation bit or power bit set.
// - Activation and power bits act as one value.
// - Base outside permitted range means host accesses are ignored.
// - Defaults reload on power-on reset or host reset line.
// - Power register 0x22 bits 0, 3, 4, 5 for floppy, parallel, serials.
// - Interrupt select bits 3 to 0 choose level; zero means none.
// - Base address decode uses host address bits 11 to 3, or 11 to 2 for a parallel base with bit 2 set.
`timescale 1ns/1ns
`include "ldcb_map.svh"
module ldcb_config_bank #(
  parameter int NUM_DEV = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic hostResetDrv,
  input wire logic configState,
  input ldcb_pkg::ldcb_host_t hostReq,
  input wire logic [15:0] hostAddr,
  input wire logic hostIoCycle,
  output logic [7:0] dataOut,
  output ldcb_pkg::ldcb_bank_t [NUM_DEV-1:0] bankState,
  output logic [NUM_DEV-1:0] deviceOn,
  output logic [NUM_DEV-1:0] ioSelect,
  output logic [NUM_DEV-1:0][15:0] irqLevelMap,
  output logic irqEdgeHigh
);
  localparam int DW = $clog2(NUM_DEV);

  // ----------------------------------------
  // Capability decoding
  // ----------------------------------------
  function automatic logic devImpl(input int d);
    return d == `LDCB_DEV_FDC || d == `LDCB_DEV_PP || d == `LDCB_DEV_SP1 ||
      d == `LDCB_DEV_SP2 || d == `LDCB_DEV_KBD;
  endfunction

  function automatic logic hasBase(input int d);
    return d == `LDCB_DEV_FDC || d == `LDCB_DEV_PP || d == `LDCB_DEV_SP1 ||
      d == `LDCB_DEV_SP2;
  endfunction

  function automatic logic hasDma(input int d);
    return d == `LDCB_DEV_FDC || d == `LDCB_DEV_PP || d == `LDCB_DEV_SP2;
  endfunction

  // Valid flag in bit 3, power bit position in bits 2..0
  function automatic logic [3:0] pwrOf(input int d);
    case (d)
      `LDCB_DEV_FDC: return `LDCB_PWR_FDC;
      `LDCB_DEV_PP: return `LDCB_PWR_PP;
      `LDCB_DEV_SP1: return `LDCB_PWR_SP1;
      `LDCB_DEV_SP2: return `LDCB_PWR_SP2;
      default: return `LDCB_PWR_NONE;
    endcase
  endfunction

  function automatic logic [15:0] levelDecode(input logic [7:0] sel);
    return (sel[3:0] == 4'h0) ? 16'h0000 : (16'h0001 << sel[3:0]);
  endfunction

  function automatic logic ioHit(input logic [15:0] base, input logic [15:0] addr,
    input logic narrow);
    logic inRange;
    logic aligned;
    logic match;
    inRange = base[11:0] >= `LDCB_BASE_MIN &&
      base[11:0] <= (narrow ? `LDCB_BASE_MAX4 : `LDCB_BASE_MAX8);
    aligned = narrow ? (base[1:0] == 2'h0) : (base[2:0] == 3'h0);
    match = narrow ? (addr[11:2] == base[11:2]) : (addr[11:3] == base[11:3]);
    return inRange && aligned && match;
  endfunction

  // ----------------------------------------
  // Host port classification
  // ----------------------------------------
  logic [7:0] idx_r;
  logic [7:0] devSel_r;
  logic [7:0] dataOut_r;
  ldcb_pkg::ldcb_acc_t acc;
  logic [7:0] bankRd [NUM_DEV];
  logic [7:0] powerView;
  logic [7:0] rdMux;
  logic [NUM_DEV-1:0] bankWe;
  logic [NUM_DEV-1:0] pwrWe;
  logic [NUM_DEV-1:0] pwrBit;

  assign acc = !configState ? ldcb_pkg::ACC_NONE :
    hostReq.idxWrite ? ldcb_pkg::ACC_INDEX :
    hostReq.dataWrite ? ldcb_pkg::ACC_WRITE :
    hostReq.dataRead ? ldcb_pkg::ACC_READ : ldcb_pkg::ACC_NONE;

  wire cfgWrite = configState && hostReq.dataWrite;
  wire cfgRead = configState && hostReq.dataRead;
  wire selValid = 32'(devSel_r) < NUM_DEV;
  wire ldIndex = idx_r >= `LDCB_IDX_LD_FIRST;
  wire devSelWe = cfgWrite && idx_r == `LDCB_IDX_DEVSEL;
  wire powerWe = cfgWrite && idx_r == `LDCB_IDX_POWER;

  // ----------------------------------------
  // Index, device select and read data
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      idx_r <= `LDCB_RST_ZERO;
    end else if (acc == ldcb_pkg::ACC_INDEX) begin
      idx_r <= hostReq.wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      devSel_r <= `LDCB_RST_ZERO;
    end else if (hostResetDrv) begin
      devSel_r <= `LDCB_RST_ZERO;
    end else if (devSelWe) begin
      devSel_r <= hostReq.wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dataOut_r <= `LDCB_RST_ZERO;
    end else if (hostReq.dataRead) begin
      dataOut_r <= cfgRead ? rdMux : `LDCB_RST_ZERO;
    end
  end
  assign dataOut = dataOut_r;

  assign rdMux = (idx_r == `LDCB_IDX_DEVSEL) ? devSel_r :
    (idx_r == `LDCB_IDX_POWER) ? powerView :
    (ldIndex && selValid) ? bankRd[devSel_r[DW-1:0]] : `LDCB_RST_ZERO;

  // Power register view built from the linked activation bits
  always_comb begin
    logic [3:0] pw;
    pw = `LDCB_PWR_NONE;
    powerView = `LDCB_RST_ZERO;
    for (int i = 0; i < NUM_DEV; i++) begin
      pw = pwrOf(i);
      if (pw[3]) begin
        powerView[pw[2:0]] = bankState[i].active;
      end
    end
  end

  // ----------------------------------------
  // Banks
  // ----------------------------------------
  for (genvar i = 0; i < NUM_DEV; i++) begin : g_dev
    localparam logic [3:0] PWR = pwrOf(i);
    assign bankWe[i] = cfgWrite && ldIndex && selValid && 32'(devSel_r) == i;
    assign pwrWe[i] = powerWe && PWR[3];
    assign pwrBit[i] = hostReq.wdata[PWR[2:0]];
    if (devImpl(i)) begin : g_impl
      ldcb_bank #(
        .HAS_BASE(hasBase(i)),
        .HAS_SEC(i == `LDCB_DEV_SP2),
        .HAS_IRQ2(i == `LDCB_DEV_KBD),
        .HAS_DMA(hasDma(i))
      ) u_bank (
        .clock(clock),
        .resetn(resetn),
        .hostResetDrv(hostResetDrv),
        .wrEn(bankWe[i]),
        .idx(idx_r),
        .wrData(hostReq.wdata),
        .pwrWr(pwrWe[i]),
        .pwrData(pwrBit[i]),
        .regs(bankState[i]),
        .rdData(bankRd[i])
      );
    end else begin : g_none
      assign bankState[i] = '0;
      assign bankRd[i] = `LDCB_RST_ZERO;
    end
    // Linked bit serves as both activation and power
    assign deviceOn[i] = bankState[i].active;
    assign ioSelect[i] = hostIoCycle && deviceOn[i] && hasBase(i) &&
      (ioHit(bankState[i].basePri, hostAddr,
        i == `LDCB_DEV_PP && bankState[i].basePri[2]) ||
      (i == `LDCB_DEV_SP2 && ioHit(bankState[i].baseSec, hostAddr, 1'b0)));
    assign irqLevelMap[i] = !deviceOn[i] ? 16'h0000 :
      (levelDecode(bankState[i].irqSel) |
      (i == `LDCB_DEV_KBD ? levelDecode(bankState[i].irqSel2) : 16'h0000));
  end

  assign irqEdgeHigh = `LDCB_IRQ_EDGE_HIGH;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  wire rdRsvd = idx_r >= `LDCB_IDX_RSVD_FIRST && idx_r <= `LDCB_IDX_RSVD_LAST;
  wire rdGap = idx_r == `LDCB_IDX_IRQ_GAP || idx_r == `LDCB_IDX_IRQ2_GAP;
  wire rdHigh = idx_r >= `LDCB_IDX_UNIMPL_FIRST && idx_r <= `LDCB_IDX_UNIMPL_LAST;
  wire kbdSel = selValid && 32'(devSel_r) == `LDCB_DEV_KBD;
  wire fdcSel = selValid && 32'(devSel_r) == `LDCB_DEV_FDC;
  wire ppSel = selValid && 32'(devSel_r) == `LDCB_DEV_PP;
  wire sp1Sel = selValid && 32'(devSel_r) == `LDCB_DEV_SP1;
  wire sp2Sel = selValid && 32'(devSel_r) == `LDCB_DEV_SP2;

  a_dev_select: assert property (
    devSelWe && !hostResetDrv |=> devSel_r == $past(hostReq.wdata))
    else $error("device select not loaded");

  a_read_outside: assert property (
    hostReq.dataRead && !configState |=> dataOut == 8'h00)
    else $error("read outside configuration state returned data");

  a_write_outside: assert property (
    !configState && !hostResetDrv |=> $stable(bankState) && $stable(devSel_r))
    else $error("register changed outside configuration state");

  a_rsvd_low: assert property (
    cfgRead && rdRsvd |=> dataOut == 8'h00)
    else $error("reserved low index read nonzero");

  a_gap_read: assert property (
    cfgRead && rdGap |=> dataOut == 8'h00)
    else $error("index 0x71 or 0x73 read nonzero");

  a_dma2_read: assert property (
    cfgRead && idx_r == `LDCB_IDX_DMA2 |=> dataOut == 8'h00)
    else $error("index 0x75 read nonzero");

  a_high_read: assert property (
    cfgRead && rdHigh |=> dataOut == 8'h00)
    else $error("unimplemented high index read nonzero");

  a_act_link: assert property (
    cfgWrite && idx_r == `LDCB_IDX_ACTIVATE && ppSel && !hostResetDrv
    |=> powerView[3'(`LDCB_PWR_PP)] == $past(hostReq.wdata[`LDCB_ACT_BIT]) &&
      deviceOn[`LDCB_DEV_PP] == powerView[3'(`LDCB_PWR_PP)])
    else $error("activation and power bit disagree");

  a_pwr_link: assert property (
    powerWe && !hostResetDrv
    |=> deviceOn[`LDCB_DEV_SP1] == $past(hostReq.wdata[3'(`LDCB_PWR_SP1)]))
    else $error("power bit did not reach activation");

  a_power_rsvd: assert property (
    cfgRead && idx_r == `LDCB_IDX_POWER |=> dataOut[7:6] == 2'h0 && dataOut[2:1] == 2'h0)
    else $error("reserved power bits read nonzero");

  a_index_load: assert property (
    acc == ldcb_pkg::ACC_INDEX |=> idx_r == $past(hostReq.wdata))
    else $error("index port write not taken");

  a_act_bits: assert property (
    cfgRead && idx_r == `LDCB_IDX_ACTIVATE |=> dataOut[7:1] == 7'h00)
    else $error("activation upper bits read nonzero");

  a_base_write: assert property (
    cfgWrite && idx_r == `LDCB_IDX_BASE_PRI_HI && fdcSel && !hostResetDrv
    |=> bankState[`LDCB_DEV_FDC].basePri[15:8] == $past(hostReq.wdata))
    else $error("primary base high byte not written");

  a_sec_write: assert property (
    cfgWrite && idx_r == `LDCB_IDX_BASE_SEC_LO && sp2Sel && !hostResetDrv
    |=> bankState[`LDCB_DEV_SP2].baseSec[7:0] == $past(hostReq.wdata))
    else $error("second base low byte not written");

  a_irq_write: assert property (
    cfgWrite && idx_r == `LDCB_IDX_IRQ && kbdSel && !hostResetDrv
    |=> bankState[`LDCB_DEV_KBD].irqSel == $past(hostReq.wdata))
    else $error("interrupt select not written");

  a_bank_isolate: assert property (
    cfgWrite && idx_r == `LDCB_IDX_IRQ && fdcSel && !hostResetDrv
    |=> $stable(bankState[`LDCB_DEV_SP1].irqSel))
    else $error("write reached an unselected bank");

  a_dma_absent: assert property (
    cfgRead && idx_r == `LDCB_IDX_DMA && sp1Sel |=> dataOut == 8'h00)
    else $error("DMA select read in a bank without it");

  a_irq2_other: assert property (
    cfgRead && idx_r == `LDCB_IDX_IRQ2 && !kbdSel |=> dataOut == 8'h00)
    else $error("second interrupt select read outside keyboard bank");

  a_base_unused: assert property (
    cfgRead && idx_r == `LDCB_IDX_BASE_SEC_HI && fdcSel |=> dataOut == 8'h00)
    else $error("unused base register read nonzero");

  a_host_reset: assert property (
    hostResetDrv |=> bankState[`LDCB_DEV_FDC].dmaSel == 8'h04 &&
      bankState[`LDCB_DEV_FDC].basePri == 16'h0000 && !deviceOn[`LDCB_DEV_FDC])
    else $error("defaults not loaded by host reset");

  a_io_range: assert property (
    ioSelect[`LDCB_DEV_FDC] |-> bankState[`LDCB_DEV_FDC].basePri[11:0] >= 12'h100 &&
      hostAddr[11:3] == bankState[`LDCB_DEV_FDC].basePri[11:3])
    else $error("select outside permitted base range");

  a_irq_level: assert property (
    deviceOn[`LDCB_DEV_SP1] && bankState[`LDCB_DEV_SP1].irqSel[3:0] == 4'h0
    |-> irqLevelMap[`LDCB_DEV_SP1] == 16'h0000)
    else $error("interrupt level zero still selects a line");

  c_activate: cover property (
    cfgWrite && idx_r == `LDCB_IDX_ACTIVATE ##1 deviceOn != '0);
  c_power_write: cover property (powerWe ##1 powerView != 8'h00);
  c_io_select: cover property (ioSelect != '0);
  c_host_reset: cover property (hostResetDrv ##1 bankState[`LDCB_DEV_FDC].dmaSel == 8'h04);
  c_bank_read: cover property (cfgRead && ldIndex && dataOut_r == 8'h00 ##1 dataOut != 8'h00);
endmodule // ldcb_config_bank

/* File: test_ldcb_config_bank.sv */
// Self-checking testbench of the logical device configuration bank
`timescale 1ns/1ns
module test_ldcb_config_bank;
  logic clock;
  logic resetn;
  logic hostResetDrv;
  logic configState;
  ldcb_pkg::ldcb_host_t hostReq;
  logic [15:0] hostAddr;
  logic hostIoCycle;
  logic [7:0] dataOut;
  ldcb_pkg::ldcb_bank_t [7:0] bankState;
  logic [7:0] deviceOn;
  logic [7:0] ioSelect;
  logic [7:0][15:0] irqLevelMap;
  logic irqEdgeHigh;
  int miscompares = 0;
  int testsRun = 0;
  // Rows: device, index, write data, expected read back
  logic [31:0] rows [0:25] = '{
    32'h00601212, 32'h00613838, 32'h00625500, 32'h0063AA00, 32'h00700606,
    32'h00720500, 32'h00740202, 32'h0031FF00, 32'h003FFF00, 32'h0040FF00,
    32'h005FFF00, 32'h0071FF00, 32'h0073FF00, 32'h0075FF00, 32'h0076FF00,
    32'h00A8FF00, 32'h00A9FF00, 32'h00DFFF00, 32'h05620303, 32'h0563F0F0,
    32'h05740101, 32'h04740300, 32'h07720C0C, 32'h07600300, 32'h07700101,
    32'h03300101};

  ldcb_config_bank #(
    .NUM_DEV(8)
  ) u_ldcb_config_bank (
    .clock(clock),
    .resetn(resetn),
    .hostResetDrv(hostResetDrv),
    .configState(configState),
    .hostReq(hostReq),
    .hostAddr(hostAddr),
    .hostIoCycle(hostIoCycle),
    .dataOut(dataOut),
    .bankState(bankState),
    .deviceOn(deviceOn),
    .ioSelect(ioSelect),
    .irqLevelMap(irqLevelMap),
    .irqEdgeHigh(irqEdgeHigh)
  );

  initial clock = 1'b0;
  always #4 clock = ~clock;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic strobe(input logic [2:0] kind, input logic [7:0] d);
    @(posedge clock);
    hostReq <= {kind, d};
    @(posedge clock);
    hostReq <= '0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    strobe(3'h4, i);
    strobe(3'h2, d);
  endtask

  task automatic rdChk(input logic [7:0] i, input logic [7:0] exp);
    strobe(3'h4, i);
    strobe(3'h1, 8'h00);
    @(negedge clock);
    chk({8'h00, dataOut}, {8'h00, exp});
  endtask

  task automatic ioChk(input logic [15:0] a, input logic cyc, input logic [7:0] exp);
    @(posedge clock);
    hostAddr <= a;
    hostIoCycle <= cyc;
    @(negedge clock);
    chk({8'h00, ioSelect}, {8'h00, exp});
  endtask

  task automatic finishTest();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    #50000;
    miscompares++;
    finishTest();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    hostResetDrv = 1'b0;
    configState = 1'b1;
    hostReq = '0;
    hostAddr = 16'h0000;
    hostIoCycle = 1'b0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    chk({8'h00, bankState[0].dmaSel}, 16'h0004);
    chk({8'h00, bankState[5].dmaSel}, 16'h0004);
    chk({8'h00, bankState[4].dmaSel}, 16'h0000);
    chk({8'h00, deviceOn}, 16'h0000);
    chk({15'h0000, irqEdgeHigh}, 16'h0001);
    rdChk(8'h74, 8'h04);
    rdChk(8'h70, 8'h00);
    for (int k = 0; k < 26; k++) begin
      wr(8'h07, rows[k][31:24]);
      wr(rows[k][23:16], rows[k][15:8]);
      rdChk(rows[k][23:16], rows[k][7:0]);
    end
    chk(bankState[0].basePri, 16'h1238);
    chk(bankState[0].baseSec, 16'h0000);
    chk(bankState[5].baseSec, 16'h03F0);
    chk({8'h00, deviceOn}, 16'h0008);
    // Outside configuration state
    wr(8'h07, 8'h00);
    rdChk(8'h70, 8'h06);
    @(posedge clock);
    configState <= 1'b0;
    wr(8'h70, 8'h09);
    strobe(3'h1, 8'h00);
    @(negedge clock);
    chk({8'h00, dataOut}, 16'h0000);
    chk({8'h00, bankState[0].irqSel}, 16'h0006);
    @(posedge clock);
    configState <= 1'b1;
    rdChk(8'h70, 8'h06);
    // Activation and power bits
    rdChk(8'h22, 8'h08);
    wr(8'h22, 8'h31);
    rdChk(8'h22, 8'h31);
    chk({8'h00, deviceOn}, 16'h0031);
    wr(8'h07, 8'h05);
    rdChk(8'h30, 8'h01);
    wr(8'h22, 8'hFF);
    rdChk(8'h22, 8'h39);
    wr(8'h07, 8'h03);
    wr(8'h30, 8'h00);
    rdChk(8'h22, 8'h31);
    chk({8'h00, deviceOn}, 16'h0031);
    // Host address decode
    wr(8'h07, 8'h04);
    wr(8'h60, 8'h02);
    wr(8'h61, 8'hF8);
    ioChk(16'h02FD, 1'b1, 8'h10);
    ioChk(16'hF2F8, 1'b1, 8'h10);
    ioChk(16'h02FD, 1'b0, 8'h00);
    ioChk(16'h0238, 1'b1, 8'h01);
    ioChk(16'h03F7, 1'b1, 8'h20);
    ioChk(16'h0300, 1'b1, 8'h00);
    wr(8'h60, 8'h00);
    ioChk(16'h00F8, 1'b1, 8'h00);
    wr(8'h60, 8'h02);
    wr(8'h61, 8'hFC);
    ioChk(16'h02FC, 1'b1, 8'h00);
    // Interrupt level map
    wr(8'h70, 8'h0F);
    @(negedge clock);
    chk(irqLevelMap[4], 16'h8000);
    chk(irqLevelMap[0], 16'h0040);
    wr(8'h70, 8'h03);
    @(negedge clock);
    chk(irqLevelMap[4], 16'h0008);
    wr(8'h70, 8'h00);
    @(negedge clock);
    chk(irqLevelMap[4], 16'h0000);
    // Host reset line
    @(posedge clock);
    hostResetDrv <= 1'b1;
    @(posedge clock);
    hostResetDrv <= 1'b0;
    @(negedge clock);
    chk(bankState[0].basePri, 16'h0000);
    chk({8'h00, bankState[0].dmaSel}, 16'h0004);
    chk({8'h00, bankState[7].irqSel2}, 16'h0000);
    chk({8'h00, deviceOn}, 16'h0000);
    rdChk(8'h22, 8'h00);
    rdChk(8'h74, 8'h04);
    finishTest();
  end
endmodule // test_ldcb_config_bank
